// *** inc/imu_timing_map.svh ***
// offsets, field positions, reset values and timing figures of the imu timing block
// assumes a 200 MHz core clock; every cycle count below is derived from it
`ifndef IMU_TIMING_MAP_SVH
`define IMU_TIMING_MAP_SVH

// ************************************************************
// register offsets (byte addresses, 16-bit registers)
// ************************************************************
`define ADDR_CMD         8'h00
`define ADDR_MISC        8'h04
`define ADDR_STATUS      8'h08
`define ADDR_IRQ_STAT    8'h0C
`define ADDR_IRQ_MASK    8'h10
`define ADDR_WORDS       8'h14

// ************************************************************
// field positions and reset values
// ************************************************************
`define CMD_SWRST        7
`define CMD_RESTORE      1
`define CMD_BACKUP       3
`define CMD_FLTEST       4
`define CMD_SELFTEST     2
`define MISC_SYNC_LSB    2
`define SYNC_DIRECT      2'h1
`define MISC_RESET       16'h0000
`define MASK_RESET       4'h0
`define EV_DONE          0
`define EV_DRDY          1
`define EV_SYNC_SHORT    2
`define EV_IGNORED       3

// ************************************************************
// timing figures in their own units, and derived cycle counts
// ************************************************************
`define CLK_MHZ          200
`define CYC_MS(t)        ((t) * `CLK_MHZ * 1000)
`define CYC_US(t)        ((t) * `CLK_MHZ)
`define T_POWERUP_MS     310
`define T_RECOVER_MS     255
`define T_RESTORE_MS     136
`define T_BACKUP_MS      70
`define T_FLTEST_MS      30
`define T_SELFTEST_MS    24
`define T_SYNC_MIN_US    5
`define SYNC_TO_DATA_READY_DELAY_US        305
`define SYNC_TO_DATA_READY_DELAY_FULL_US   405
`define SAMPLE_HZ        2000
`define FULL_WORDS       64
`define WORD_BITS        16
`define SAMPLE_CYC       (`CLK_MHZ * 1000000 / `SAMPLE_HZ)
`define SELFTEST_SAMPLES (`T_SELFTEST_MS * `SAMPLE_HZ / 1000)
`define STDR_PER_WORD    (`CYC_US(`SYNC_TO_DATA_READY_DELAY_FULL_US - `SYNC_TO_DATA_READY_DELAY_US) / `FULL_WORDS)

`endif

// *** inc/imu_timing_pkg.sv ***
// types shared by the imu timing block
// assumes nothing of its surroundings
package imu_timing_pkg;

    // ************************************************************
    // sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_POWERUP  = 3'b000,
        ST_READY    = 3'b001,
        ST_RST_HOLD = 3'b010,
        ST_RECOVER  = 3'b011,
        ST_RESTORE  = 3'b100,
        ST_BACKUP   = 3'b101,
        ST_FLTEST   = 3'b110,
        ST_SELFTEST = 3'b111
    } state_e;

endpackage

// *** inc/pin_sync_if.sv ***
// bundle between the imu timing top and its pin synchroniser
// assumes one clock domain; the raw side comes from package pins
`timescale 1ns/1ps
interface pin_sync_if;
    logic       ce;
    logic [3:0] raw;
    logic [3:0] synced;
    modport syncer (input ce, input raw, output synced);
    modport user   (output ce, output raw, input synced);
endinterface

// *** hdl/pin_sync.sv ***
// two-flop synchroniser for all asynchronous pins of the imu timing block
// assumes the raw inputs may change at any time relative to clk_i
`timescale 1ns/1ps
module pin_sync #(
    parameter logic [3:0] RESET_VAL = 4'h0
) (
    input  wire logic    clk_i,
    input  wire logic    rst_b_i,
    pin_sync_if.syncer   pins
);
    logic [3:0] meta_q;
    logic [3:0] sync_q;

    // first stage is read only by the second stage
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else if (pins.ce) begin
            meta_q <= pins.raw;
            sync_q <= meta_q;
        end
    end

    assign pins.synced = sync_q;
endmodule

// *** hdl/imu_timing.sv ***
// sequencing and sync-to-data-ready timing of an inertial sensor host interface
// assumes a register master on clk_i; reset pin, sync, serial clock and select are async pins
//
// Summary of operation
// - after power-up, no data ready until 310 ms have passed
// - command bit 7 soft reset; data again no sooner than 255 ms
// - command bit 1 restores factory calibration, busy for 136 ms
// - command bit 3 backs configuration up to flash, busy for 70 ms
// - command bit 4 tests flash integrity, done after 30 ms
// - command bit 2 runs sensor self test, done after 24 ms
// - with external sample clock below 2000 Hz self test may run longer
// - direct sync, no traffic: data ready 305 us after sync edge
// - direct sync, 64 words read: data ready after 405 us
// - sync-to-ready delay grows with words the host still reads
`timescale 1ns/1ps
`include "imu_timing_map.svh"
module imu_timing #(
    parameter int unsigned POWERUP_CYC  = `CYC_MS(`T_POWERUP_MS),
    parameter int unsigned RECOVER_CYC  = `CYC_MS(`T_RECOVER_MS),
    parameter int unsigned RESTORE_CYC  = `CYC_MS(`T_RESTORE_MS),
    parameter int unsigned BACKUP_CYC   = `CYC_MS(`T_BACKUP_MS),
    parameter int unsigned FLTEST_CYC   = `CYC_MS(`T_FLTEST_MS),
    parameter int unsigned SELFTEST_CYC = `CYC_MS(`T_SELFTEST_MS),
    parameter int unsigned SAMPLE_CYC   = `SAMPLE_CYC,
    parameter int unsigned STDR_CYC     = `CYC_US(`SYNC_TO_DATA_READY_DELAY_US)
) (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ce_i,
    input  wire logic        rst_pin_b_i,
    input  wire logic        sync_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_b_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    output logic             data_ready_o,
    output logic             busy_o,
    output logic             irq_o
);
    localparam int unsigned SYNC_MIN_CYC = `CYC_US(`T_SYNC_MIN_US);
    localparam int unsigned PER_WORD     = `STDR_PER_WORD;
    localparam int          ST_SAMPLES   = `SELFTEST_SAMPLES;

    // ************************************************************
    // pin synchronisation
    // ************************************************************
    pin_sync_if pins ();
    logic pin_rst_b;
    logic sync_s;
    logic sclk_s;
    logic cs_b_s;

    assign pins.ce  = ce_i;
    assign pins.raw = {cs_b_i, sclk_i, sync_i, rst_pin_b_i};
    assign {cs_b_s, sclk_s, sync_s, pin_rst_b} = pins.synced;

    pin_sync #(.RESET_VAL(4'hD)) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .pins    (pins)
    );

    logic sync_d1_q;
    logic sclk_d1_q;

    // edge history of the synchronised sync and serial clock pins; resets to the idle levels so no false edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_d1_q <= 1'b0;
            sclk_d1_q <= 1'b1;
        end else if (ce_i) begin
            sync_d1_q <= sync_s;
            sclk_d1_q <= sclk_s;
        end
    end

    logic sync_rise;
    logic sync_fall;
    logic sclk_rise;
    assign sync_rise = sync_s & ~sync_d1_q;
    assign sync_fall = ~sync_s & sync_d1_q;
    assign sclk_rise = sclk_s & ~sclk_d1_q & ~cs_b_s;

    // ************************************************************
    // registers written by software
    // ************************************************************
    logic [15:0] misc_q;
    logic [3:0]  mask_q;
    logic        direct_mode;
    logic        cmd_wr;
    imu_timing_pkg::state_e state_q;
    imu_timing_pkg::state_e state_d;

    assign direct_mode = misc_q[`MISC_SYNC_LSB +: 2] == `SYNC_DIRECT;
    assign cmd_wr      = wr_i && (addr_i == `ADDR_CMD);

    // soft and pin reset return the control register to its default
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            misc_q <= `MISC_RESET;
            mask_q <= `MASK_RESET;
        end else if (ce_i) begin
            if (state_d == imu_timing_pkg::ST_RST_HOLD ||
                (state_q == imu_timing_pkg::ST_READY &&
                 state_d == imu_timing_pkg::ST_RECOVER)) begin
                misc_q <= `MISC_RESET;
            end else if (wr_i && addr_i == `ADDR_MISC) begin
                misc_q <= wdata_i;
            end
            if (wr_i && addr_i == `ADDR_IRQ_MASK) begin
                mask_q <= wdata_i[3:0];
            end
        end
    end

    // ************************************************************
    // command sequencer
    // ************************************************************
    logic [31:0] timer_q;
    logic [7:0]  st_cnt_q;
    logic        timer_zero;
    logic        sample_tick;
    assign timer_zero = timer_q == 32'h0000_0000;

    // one command at a time, soft reset wins over the others
    always_comb begin
        state_d = state_q;
        if (!pin_rst_b) begin
            state_d = imu_timing_pkg::ST_RST_HOLD;
        end else begin
            case (state_q)
                imu_timing_pkg::ST_RST_HOLD: state_d = imu_timing_pkg::ST_RECOVER;
                imu_timing_pkg::ST_SELFTEST: begin
                    if (timer_zero && st_cnt_q >= 8'(ST_SAMPLES)) begin
                        state_d = imu_timing_pkg::ST_READY;
                    end
                end
                imu_timing_pkg::ST_READY: begin
                    if (cmd_wr && wdata_i[`CMD_SWRST]) begin
                        state_d = imu_timing_pkg::ST_RECOVER;
                    end else if (cmd_wr && wdata_i[`CMD_RESTORE]) begin
                        state_d = imu_timing_pkg::ST_RESTORE;
                    end else if (cmd_wr && wdata_i[`CMD_BACKUP]) begin
                        state_d = imu_timing_pkg::ST_BACKUP;
                    end else if (cmd_wr && wdata_i[`CMD_FLTEST]) begin
                        state_d = imu_timing_pkg::ST_FLTEST;
                    end else if (cmd_wr && wdata_i[`CMD_SELFTEST]) begin
                        state_d = imu_timing_pkg::ST_SELFTEST;
                    end
                end
                default: begin
                    if (timer_zero) begin
                        state_d = imu_timing_pkg::ST_READY;
                    end
                end
            endcase
        end
    end

    // interval length of a state, counted from the cycle it is entered
    function automatic logic [31:0] dur(input imu_timing_pkg::state_e s);
        case (s)
            imu_timing_pkg::ST_RECOVER:  dur = 32'(RECOVER_CYC - 1);
            imu_timing_pkg::ST_RESTORE:  dur = 32'(RESTORE_CYC - 1);
            imu_timing_pkg::ST_BACKUP:   dur = 32'(BACKUP_CYC - 1);
            imu_timing_pkg::ST_FLTEST:   dur = 32'(FLTEST_CYC - 1);
            imu_timing_pkg::ST_SELFTEST: dur = 32'(SELFTEST_CYC - 1);
            default:                     dur = 32'h0000_0000;
        endcase
    endfunction

    // state register; power-up interval starts at reset release
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= imu_timing_pkg::ST_POWERUP;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    // interval timer loads on every state change and runs down to zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            timer_q <= 32'(POWERUP_CYC - 1);
        end else if (ce_i) begin
            if (state_d != state_q) begin
                timer_q <= dur(state_d);
            end else if (!timer_zero) begin
                timer_q <= timer_q - 32'h0000_0001;
            end
        end
    end

    // self test also waits for enough samples, so a slow external clock stretches it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_cnt_q <= 8'h00;
        end else if (ce_i) begin
            if (state_q != imu_timing_pkg::ST_SELFTEST) begin
                st_cnt_q <= 8'h00;
            end else if (sample_tick && st_cnt_q != 8'hFF) begin
                st_cnt_q <= st_cnt_q + 8'h01;
            end
        end
    end

    // ************************************************************
    // sample timing and data ready
    // ************************************************************
    logic [31:0] sample_q;
    logic [31:0] stdr_q;
    logic        stdr_run_q;
    logic [3:0]  bit_cnt_q;
    logic [6:0]  words_q;
    logic        word_done;
    logic        ready;
    logic        stdr_end;

    assign ready       = state_q == imu_timing_pkg::ST_READY;
    assign sample_tick = direct_mode ? sync_rise : (sample_q == 32'h0000_0000);
    assign word_done   = sclk_rise && bit_cnt_q == 4'(`WORD_BITS - 1);
    assign stdr_end    = stdr_run_q && stdr_q == 32'h0000_0000;

    // internal sample clock, free running
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sample_q <= 32'(SAMPLE_CYC - 1);
        end else if (ce_i) begin
            sample_q <= (sample_q == 32'h0000_0000) ? 32'(SAMPLE_CYC - 1) :
                        sample_q - 32'h0000_0001;
        end
    end

    // serial traffic is only observed, one word per sixteen clock edges
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_cnt_q <= 4'h0;
        end else if (ce_i) begin
            if (cs_b_s) begin
                bit_cnt_q <= 4'h0;
            end else if (sclk_rise) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    // sync latency: base delay plus a share per word read while it runs
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stdr_q     <= 32'h0000_0000;
            stdr_run_q <= 1'b0;
            words_q    <= 7'h00;
        end else if (ce_i) begin
            if (!ready || !direct_mode) begin
                stdr_run_q <= 1'b0;
            end else if (sync_rise) begin
                stdr_q     <= 32'(STDR_CYC - 1);
                stdr_run_q <= 1'b1;
                words_q    <= 7'h00;
            end else if (stdr_end) begin
                stdr_run_q <= 1'b0;
            end else if (stdr_run_q) begin
                if (word_done && words_q != 7'(`FULL_WORDS)) begin
                    stdr_q  <= stdr_q - 32'h0000_0001 + 32'(PER_WORD);
                    words_q <= words_q + 7'h01;
                end else begin
                    stdr_q <= stdr_q - 32'h0000_0001;
                end
            end
        end
    end

    logic drdy_q;
    logic drdy_set;
    assign drdy_set = ready && (direct_mode ? stdr_end : sample_tick);

    // a new acquisition invalidates the previous sample; busy intervals hold it off
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drdy_q <= 1'b0;
        end else if (ce_i) begin
            if (!ready) begin
                drdy_q <= 1'b0;
            end else if (drdy_set) begin
                drdy_q <= 1'b1;
            end else if (sync_rise) begin
                drdy_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // interrupts and register reads
    // ************************************************************
    logic [3:0]  irq_q;
    logic [3:0]  ev;
    logic [15:0] sync_w_q;
    logic [15:0] rdata_q;

    // pulse width guard; the counter saturates well above the minimum
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_w_q <= 16'h0000;
        end else if (ce_i) begin
            if (!sync_s) begin
                sync_w_q <= 16'h0000;
            end else if (sync_w_q != 16'hFFFF) begin
                sync_w_q <= sync_w_q + 16'h0001;
            end
        end
    end

    assign ev[`EV_DONE]       = !ready && state_d == imu_timing_pkg::ST_READY;
    assign ev[`EV_DRDY]       = drdy_set;
    assign ev[`EV_SYNC_SHORT] = direct_mode && sync_fall && sync_w_q < 16'(SYNC_MIN_CYC);
    assign ev[`EV_IGNORED]    = cmd_wr && !ready && wdata_i != 16'h0000;

    // sticky events; read clears, a same-cycle event wins
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_q <= 4'h0;
        end else if (ce_i) begin
            irq_q <= ((rd_i && addr_i == `ADDR_IRQ_STAT) ? 4'h0 : irq_q) | ev;
        end
    end

    // read data stand one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 16'h0000;
        end else if (ce_i) begin
            if (!rd_i) begin
                rdata_q <= 16'h0000;
            end else if (addr_i == `ADDR_MISC) begin
                rdata_q <= misc_q;
            end else if (addr_i == `ADDR_STATUS) begin
                rdata_q <= {11'h000, drdy_q, !ready, state_q};
            end else if (addr_i == `ADDR_IRQ_STAT) begin
                rdata_q <= {12'h000, irq_q};
            end else if (addr_i == `ADDR_IRQ_MASK) begin
                rdata_q <= {12'h000, mask_q};
            end else if (addr_i == `ADDR_WORDS) begin
                rdata_q <= {9'h000, words_q};
            end else begin
                rdata_q <= 16'h0000;
            end
        end
    end

    assign rdata_o      = rdata_q;
    assign data_ready_o = drdy_q;
    assign busy_o       = !ready;
    assign irq_o        = |(irq_q & mask_q);

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    powerup_quiet_a: assert property (
        state_q == imu_timing_pkg::ST_POWERUP |-> !drdy_q)
        else $error("data ready during power-up");
    pin_recover_a: assert property (
        ce_i && state_q == imu_timing_pkg::ST_RST_HOLD && pin_rst_b |=>
        state_q == imu_timing_pkg::ST_RECOVER && timer_q == 32'(RECOVER_CYC - 1))
        else $error("pin reset release did not start recovery");
    soft_reset_a: assert property (
        ce_i && ready && pin_rst_b && cmd_wr && wdata_i[`CMD_SWRST] |=>
        state_q == imu_timing_pkg::ST_RECOVER && timer_q == 32'(RECOVER_CYC - 1)
        && misc_q == `MISC_RESET)
        else $error("soft reset not started");
    restore_start_a: assert property (
        ce_i && ready && pin_rst_b && cmd_wr && wdata_i[7:0] == 8'h02 |=>
        state_q == imu_timing_pkg::ST_RESTORE && timer_q == 32'(RESTORE_CYC - 1))
        else $error("restore not started");
    backup_start_a: assert property (
        ce_i && ready && pin_rst_b && cmd_wr && wdata_i[7:0] == 8'h08 |=>
        state_q == imu_timing_pkg::ST_BACKUP && timer_q == 32'(BACKUP_CYC - 1))
        else $error("backup not started");
    fltest_start_a: assert property (
        ce_i && ready && pin_rst_b && cmd_wr && wdata_i[7:0] == 8'h10 |=>
        state_q == imu_timing_pkg::ST_FLTEST && timer_q == 32'(FLTEST_CYC - 1))
        else $error("flash test not started");
    selftest_len_a: assert property (
        ce_i && ready && pin_rst_b && cmd_wr && wdata_i[7:0] == 8'h04 |=>
        state_q == imu_timing_pkg::ST_SELFTEST && timer_q == 32'(SELFTEST_CYC - 1))
        else $error("self test not started");
    selftest_end_a: assert property (
        state_q == imu_timing_pkg::ST_SELFTEST && pin_rst_b &&
        state_d == imu_timing_pkg::ST_READY |-> st_cnt_q >= 8'(ST_SAMPLES))
        else $error("self test ended before enough samples");
    stdr_base_a: assert property (
        ce_i && ready && direct_mode && sync_rise && state_d == imu_timing_pkg::ST_READY
        |=> stdr_run_q && stdr_q == 32'(STDR_CYC - 1))
        else $error("sync latency not loaded");
    stdr_grow_a: assert property (
        ce_i && ready && direct_mode && stdr_run_q && !stdr_end && !sync_rise &&
        word_done && words_q != 7'(`FULL_WORDS) && state_d == imu_timing_pkg::ST_READY
        |=> stdr_q == $past(stdr_q) - 32'h0000_0001 + 32'(PER_WORD))
        else $error("sync latency did not grow with traffic");
    busy_hold_a: assert property (
        !ready && $past(!ready && ce_i) |-> !drdy_q)
        else $error("data ready while busy");
    cmd_ignored_a: assert property (
        ce_i && !ready && pin_rst_b && cmd_wr && timer_q > 32'h0000_0001 &&
        state_q != imu_timing_pkg::ST_RST_HOLD |=>
        state_q == $past(state_q))
        else $error("command taken while busy");

    direct_drdy_c:  cover property (ready && direct_mode && stdr_end);
    busy_cmd_c:     cover property (ev[`EV_IGNORED]);
    selftest_done_c: cover property (state_q == imu_timing_pkg::ST_SELFTEST &&
                                     state_d == imu_timing_pkg::ST_READY);
    traffic_c:      cover property (stdr_run_q && word_done);
endmodule

// *** tb/imu_host.sv ***
// host model: drives the sync pin and the serial select and clock pins
// assumes the bench calls its tasks; link clock period 64 ns
`timescale 1ns/1ps
module imu_host (
    output logic sclk_o,
    output logic cs_b_o,
    output logic sync_o
);
    // ********
    // idle: select high, link clock stands still high
    // ********
    initial begin
        sclk_o = 1'b1;
        cs_b_o = 1'b1;
        sync_o = 1'b0;
    end
    // pulse kept above 5 us so the short-pulse flag stays clear
    // non-blocking so a change that lands on a clock edge never races the sampler
    task automatic pulse();
        sync_o <= 1'b1;
        #5100 sync_o <= 1'b0;
    endtask
    // burst read: words back to back, no stall between them
    task automatic words(input int k);
        cs_b_o <= 1'b0;
        repeat (k * 16) begin
            #32 sclk_o <= 1'b0;
            #32 sclk_o <= 1'b1;
        end
        #40 cs_b_o <= 1'b1;
    endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench of the imu timing block
// assumes shortened interval parameters; ce_i dropped once to freeze a command
`timescale 1ns/1ps
`include "imu_timing_map.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
    $display("ERROR %s exp %0h got %0h", n, e, s); end end
module tb;
    localparam int PU = 200, RC = 300, RS = 250, BK = 220, FT = 210, SF = 200;
    localparam int SC = 100, ST = 500;
    logic        clk_i, rst_b_i, ce_i, rst_pin_b_i, wr_i, rd_i, sync_i, sclk_i, cs_b_i;
    logic        data_ready_o, busy_o, irq_o;
    logic [7:0]  addr_i;
    logic [15:0] wdata_i, rdata_o, d;
    int          err_total, comparisons, n, k, cyc, e, lo, hi;
    int          cmds[5] = '{`CMD_SWRST, `CMD_RESTORE, `CMD_BACKUP, `CMD_FLTEST, `CMD_SELFTEST};
    imu_timing #(.POWERUP_CYC(PU), .RECOVER_CYC(RC), .RESTORE_CYC(RS),
        .BACKUP_CYC(BK), .FLTEST_CYC(FT), .SELFTEST_CYC(SF),
        .SAMPLE_CYC(SC), .STDR_CYC(ST)) imu_timing_i (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .ce_i(ce_i), .rst_pin_b_i(rst_pin_b_i),
        .sync_i(sync_i), .sclk_i(sclk_i), .cs_b_i(cs_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .data_ready_o(data_ready_o), .busy_o(busy_o), .irq_o(irq_o));
    imu_host imu_host_i (.sclk_o(sclk_i), .cs_b_o(cs_b_i), .sync_o(sync_i));
    // ********
    // clock, timeout and helpers
    // ********
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // a hang ends the run rather than stalling it
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            close_out();
        end
    end
    // busy cycles seen by wait_idle; self test gives the earliest end of a window
    // one sample period wide, since the sample phase runs free
    function automatic int dur(input int b);
        case (b)
            `CMD_SWRST:   return RC;
            `CMD_RESTORE: return RS - 2; // the refused second write delays the wait
            `CMD_BACKUP:  return BK;
            `CMD_FLTEST:  return FT - 1; // one busy cycle passes before the freeze
            default:      return (`SELFTEST_SAMPLES - 1) * SC + 2;
        endcase
    endfunction
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_i) begin addr_i <= a; wdata_i <= v; wr_i <= 1'b1; end
        @(posedge clk_i) wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i) begin addr_i <= a; rd_i <= 1'b1; end
        @(posedge clk_i) rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic wait_idle();
        n = 0;
        do begin @(posedge clk_i); #1 n++; end while (busy_o === 1'b1 && n < 9000);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ********
    // main sequence
    // ********
    initial begin
        {rst_b_i, wr_i, rd_i, addr_i, wdata_i} = '0;
        {ce_i, rst_pin_b_i} = 2'b11;
        k = $urandom(54);
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        wait_idle();
        `CHK("powerup", 1'b1, n >= 199 && n <= 203)
        wr(`ADDR_IRQ_MASK, 16'h0001);
        // each command, restore with a second command thrown at it
        foreach (cmds[i]) begin
            e = cmds[i];
            wr(`ADDR_CMD, 16'h0001 << e);
            if (e == `CMD_RESTORE) wr(`ADDR_CMD, 16'h0001 << `CMD_BACKUP);
            // a clock-enable gap must stretch the interval by exactly its length
            if (e == `CMD_FLTEST) begin
                @(posedge clk_i) ce_i <= 1'b0;
                repeat (40) @(posedge clk_i);
                ce_i <= 1'b1;
            end
            wait_idle();
            lo = dur(e);
            hi = (e == `CMD_SELFTEST) ? lo + SC - 1 : lo;
            `CHK("cmd", 1'b1, n >= lo && n <= hi)
            if (e == `CMD_RESTORE) begin
                `CHK("irq", 1'b1, irq_o)
                rd(`ADDR_IRQ_STAT);
                `CHK("ignored", 16'h0009, d & 16'h0009)
                `CHK("irq clr", 1'b0, irq_o)
            end
        end
        rd(`ADDR_CMD);
        `CHK("cmd rd", 16'h0000, d)
        wr(`ADDR_MISC, 16'h0004);
        // direct sync: latency grows with words read in the wait
        for (int i = 0; i < 4; i++) begin
            k = (i == 0) ? 0 : $urandom_range(1, 4);
            fork
                imu_host_i.pulse();
                begin #200 imu_host_i.words(k); end
            join_none
            @(posedge clk_i iff sync_i);
            n = 0;
            // the old data ready only falls two edges after the detect, so skip that stretch
            while ((data_ready_o !== 1'b1 || n < 3) && n < 3000) begin @(posedge clk_i); #1 n++;
                if (n == 10) `CHK("dr clr", 1'b0, data_ready_o)
            end
            e = ST + `STDR_PER_WORD * k;
            `CHK("stdr", 1'b1, n >= e + 1 && n <= e + 6)
            repeat (1200) @(posedge clk_i);
        end
        // pin reset: recovery runs and control register clears
        @(posedge clk_i) rst_pin_b_i <= 1'b0;
        repeat (2000) @(posedge clk_i);
        rst_pin_b_i <= 1'b1;
        wait_idle();
        `CHK("recover", 1'b1, n >= 301 && n <= 306)
        rd(`ADDR_MISC);
        `CHK("misc", 16'h0000, d)
        close_out();
    end
endmodule
